// ---- hw/icbou_top.sv ----
// execution datapath: invert, negate, subtract-test and single-bit ops
// assumes decoder drives one op per cycle with i_valid on the core clock
`include "icbou_defines.svh"
module icbou_top #(
  parameter int DW = `ICBOU_DW
) (
  input  wire logic             i_clk,
  input  wire logic             i_sys_rst,
  input  wire logic             i_valid,
  input  wire icbou_pkg::icbou_op_t i_op,
  input  wire logic             i_mem_sel,
  input  wire logic [2:0]       i_bit_idx,
  input  wire logic [DW-1:0]    i_mem_rdata,
  input  wire logic [DW-1:0]    i_port_dir,
  input  wire logic [DW-1:0]    i_port_one_pins,
  input  wire logic             i_flag_wr,
  input  wire logic [`ICBOU_FW-1:0] i_flag_wdata,
  input  wire logic             i_wreg_wr,
  input  wire logic [DW-1:0]    i_wreg_wdata,
  output logic      [DW-1:0]    o_working_reg,
  output logic      [DW-1:0]    o_port_data,
  output logic      [`ICBOU_FW-1:0] o_flags,
  output logic      [DW-1:0]    o_mem_wdata,
  output logic                  o_mem_we
);
  // ************************************************************
  // elaboration checks
  // ************************************************************
  if (DW != 8) begin : g_bad_dw
    $error("icbou_top supports only an 8-bit datapath");
  end

  // ************************************************************
  // state registers
  // ************************************************************
  logic [DW-1:0]        wreg_q,  wreg_d;   // working register
  logic [DW-1:0]        port_q,  port_d;   // port data latch
  logic [`ICBOU_FW-1:0] flag_q,  flag_d;   // flag register
  logic [DW-1:0]        mwd_q,   mwd_d;    // memory write data
  logic                 mwe_q,   mwe_d;    // memory write strobe

  // ************************************************************
  // decode
  // ************************************************************
  wire go_w       = i_valid;
  wire op_not_w   = go_w && (i_op == icbou_pkg::ICBOU_OP_NOT_WREG);
  wire op_not_m   = go_w && (i_op == icbou_pkg::ICBOU_OP_NOT_MEM);
  wire op_neg_w   = go_w && (i_op == icbou_pkg::ICBOU_OP_NEG_WREG);
  wire op_neg_m   = go_w && (i_op == icbou_pkg::ICBOU_OP_NEG_MEM);
  wire op_cmp_wm  = go_w && (i_op == icbou_pkg::ICBOU_OP_CMP_WM);
  wire op_cmp_mw  = go_w && (i_op == icbou_pkg::ICBOU_OP_CMP_MW);
  wire op_clr     = go_w && (i_op == icbou_pkg::ICBOU_OP_PORT_CLR);
  wire op_set     = go_w && (i_op == icbou_pkg::ICBOU_OP_PORT_SET);
  wire op_xch     = go_w && (i_op == icbou_pkg::ICBOU_OP_PORT_XCH) && !i_mem_sel;
  // bit-clear / bit-force-high land on port or memory
  wire bit_clear_op_port      = op_clr && !i_mem_sel;
  wire bit_force_high_op_port = op_set && !i_mem_sel;
  wire bit_clear_op_mem       = op_clr && i_mem_sel;
  wire bit_force_high_op_mem  = op_set && i_mem_sel;

  // ************************************************************
  // bit mask and subtract helper
  // ************************************************************
  logic [DW-1:0] mask_w;  // one-hot select of bit n
  icbou_bitsel #(.W(DW)) u_bitsel (
    .i_idx  (i_bit_idx),
    .o_mask (mask_w)
  );

  icbou_sub_if sub_if ();
  assign sub_if.minuend    = op_cmp_mw ? i_mem_rdata : wreg_q;
  assign sub_if.subtrahend = op_cmp_mw ? wreg_q : i_mem_rdata;
  icbou_sub u_sub (
    .s (sub_if)
  );

  // ************************************************************
  // result selection
  // ************************************************************
  // ones complement
  wire [DW-1:0] inv_w_w = ~wreg_q;
  wire [DW-1:0] inv_m_w = ~i_mem_rdata;
  wire [DW-1:0] neg_w_w = DW'(inv_w_w + 8'h01);
  wire [DW-1:0] neg_m_w = DW'(inv_m_w + 8'h01);
  wire [DW-1:0] unary_w = op_not_w ? inv_w_w : op_not_m ? inv_m_w :
                          op_neg_w ? neg_w_w : neg_m_w;
  wire unary_op_w = op_not_w | op_not_m | op_neg_w | op_neg_m;
  wire [DW-1:0] mem_bit_w = bit_clear_op_mem ? (i_mem_rdata & ~mask_w)
                                             : (i_mem_rdata | mask_w);
  // selected direction bit, one means output
  wire sel_out_w  = |(i_port_dir & mask_w);
  wire sel_pin_w  = |(i_port_one_pins & mask_w);
  wire old_borr_w = flag_q[`ICBOU_FLG_BORR];

  // ************************************************************
  // next-state logic
  // ************************************************************
  // compute next values for all registers
  always_comb begin
    wreg_d = wreg_q;
    port_d = port_q;
    flag_d = flag_q;
    mwd_d  = mwd_q;
    mwe_d  = 1'b0;
    // software flag write, lowest priority
    if (i_flag_wr) begin
      flag_d = i_flag_wdata;
    end
    if (i_wreg_wr) begin
      wreg_d = i_wreg_wdata;
    end
    if (op_not_w || op_neg_w) begin
      wreg_d = unary_w;
    end
    if (op_not_m || op_neg_m) begin
      mwd_d = unary_w;
      mwe_d = 1'b1;
    end
    // only null flag changes on unary ops
    if (unary_op_w) begin
      flag_d[`ICBOU_FLG_NULL] = (unary_w == `ICBOU_RST_BYTE);
    end
    if (op_cmp_wm || op_cmp_mw) begin
      flag_d[`ICBOU_FLG_NULL] = sub_if.null_f;
      flag_d[`ICBOU_FLG_BORR] = sub_if.borr_f;
      flag_d[`ICBOU_FLG_HALF] = sub_if.half_f;
      flag_d[`ICBOU_FLG_WRAP] = sub_if.wrap_f;
    end
    if (bit_clear_op_port) begin
      port_d = port_q & ~mask_w;
    end
    if (bit_force_high_op_port) begin
      port_d = port_q | mask_w;
    end
    if (bit_clear_op_mem || bit_force_high_op_mem) begin
      mwd_d = mem_bit_w;
      mwe_d = 1'b1;
    end
    if (op_xch) begin
      if (sel_out_w) begin
        port_d = old_borr_w ? (port_q | mask_w) : (port_q & ~mask_w);
        flag_d[`ICBOU_FLG_BORR] = |(port_q & mask_w);
      end else begin
        flag_d[`ICBOU_FLG_BORR] = sel_pin_w;
      end
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  // borrow held at flag bit one
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wreg_q <= `ICBOU_RST_BYTE;
      port_q <= `ICBOU_RST_BYTE;
      flag_q <= `ICBOU_RST_FLAG;
      mwd_q  <= `ICBOU_RST_BYTE;
      mwe_q  <= 1'b0;
    end else begin
      wreg_q <= wreg_d;
      port_q <= port_d;
      flag_q <= flag_d;
      mwd_q  <= mwd_d;
      mwe_q  <= mwe_d;
    end
  end

  assign o_working_reg = wreg_q;
  assign o_port_data   = port_q;
  assign o_flags       = flag_q;
  assign o_mem_wdata   = mwd_q;
  assign o_mem_we      = mwe_q;

  // ************************************************************
  // assertion helpers
  // ************************************************************
  // any operation that writes the memory byte back
  wire       mem_op_w    = op_not_m | op_neg_m | bit_clear_op_mem | bit_force_high_op_mem;
  // compare in either operand order
  wire       cmp_op_w    = op_cmp_wm | op_cmp_mw;
  // exchange presented with a memory operand, which is refused
  wire       xch_mem_w   = go_w && (i_op == icbou_pkg::ICBOU_OP_PORT_XCH) && i_mem_sel;
  // flags above the null flag, kept by unary ops
  wire [2:0] upper_f_w   = flag_q[`ICBOU_FLG_WRAP:`ICBOU_FLG_BORR];
  // flags other than borrow, kept by the exchange
  wire [2:0] no_borr_f_w = {flag_q[`ICBOU_FLG_WRAP:`ICBOU_FLG_HALF], flag_q[`ICBOU_FLG_NULL]};

  // ************************************************************
  // assertions
  // ************************************************************
  a_not_wreg_value: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    op_not_w && !i_wreg_wr && !i_flag_wr |=> (wreg_q == ~$past(wreg_q))
      && (flag_q[3:1] == $past(flag_q[3:1])))
    else $error("invert of working register wrong");
  a_not_mem_value: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    op_not_m && !i_flag_wr |=> o_mem_we && (o_mem_wdata == ~$past(i_mem_rdata))
      && (flag_q[3:1] == $past(flag_q[3:1])))
    else $error("invert of memory wrong");
  a_neg_wreg_value: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    op_neg_w && !i_wreg_wr |=> (DW'(wreg_q + $past(wreg_q)) == 8'h00)
      && (flag_q[`ICBOU_FLG_NULL] == (wreg_q == 8'h00)))
    else $error("negate of working register wrong");
  a_neg_mem_value: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    op_neg_m && !i_flag_wr |=> (DW'(o_mem_wdata + $past(i_mem_rdata)) == 8'h00)
      && (flag_q[3:1] == $past(flag_q[3:1])))
    else $error("negate of memory wrong");
  a_cmp_no_store: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (op_cmp_wm || op_cmp_mw) && !i_wreg_wr |=> !o_mem_we && $stable(wreg_q))
    else $error("compare stored a result");
  a_cmp_equal_null: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (op_cmp_wm || op_cmp_mw) && (wreg_q == i_mem_rdata)
      |=> flag_q[`ICBOU_FLG_NULL] && !flag_q[`ICBOU_FLG_BORR])
    else $error("equal compare did not set null flag");
  a_cmp_borrow: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    op_cmp_mw |=> flag_q[`ICBOU_FLG_BORR] == ($past(i_mem_rdata) < $past(wreg_q)))
    else $error("compare borrow flag wrong");
  a_port_clear: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    bit_clear_op_port |=> ((o_port_data & $past(mask_w)) == 8'h00)
      && ((o_port_data | $past(mask_w)) == ($past(port_q) | $past(mask_w))))
    else $error("port bit clear wrong");
  a_port_set: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    bit_force_high_op_port && !i_flag_wr |=> ((o_port_data & $past(mask_w)) != 8'h00)
      && $stable(flag_q))
    else $error("port bit set wrong");
  a_xch_output: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    op_xch && sel_out_w |=> (|(o_port_data & $past(mask_w))) == $past(old_borr_w))
    else $error("exchange did not drive old borrow");
  a_xch_input: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    op_xch && !sel_out_w |=> flag_q[`ICBOU_FLG_BORR] == $past(sel_pin_w)
      && $stable(o_port_data))
    else $error("exchange did not load pin level");
  a_mem_bit_set: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    bit_force_high_op_mem |=> o_mem_we && (o_mem_wdata == ($past(i_mem_rdata) | $past(mask_w))))
    else $error("memory bit set wrong");

  // ************************************************************
  // unary and compare checks
  // ************************************************************
  // null flag of negated byte
  a_neg_mem_null: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    op_neg_m |=> flag_q[`ICBOU_FLG_NULL] == (o_mem_wdata == 8'h00))
    else $error("negate of memory null flag wrong");
  a_neg_wreg_flags: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    op_neg_w && !i_flag_wr |=> upper_f_w == $past(upper_f_w))
    else $error("negate of working register touched flags");
  // half borrow of working minus memory
  a_cmp_half: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    op_cmp_wm |=> flag_q[`ICBOU_FLG_HALF] == ($past(wreg_q[3:0]) < $past(i_mem_rdata[3:0])))
    else $error("compare half borrow flag wrong");
  a_cmp_wm_borrow: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    op_cmp_wm |=> flag_q[`ICBOU_FLG_BORR] == ($past(wreg_q) < $past(i_mem_rdata)))
    else $error("working minus memory borrow wrong");
  // null flag of memory minus working
  a_cmp_mw_null: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    op_cmp_mw |=> flag_q[`ICBOU_FLG_NULL] == ($past(i_mem_rdata) == $past(wreg_q)))
    else $error("memory minus working null flag wrong");
  a_cmp_no_port: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    cmp_op_w |=> $stable(o_port_data))
    else $error("compare changed the port latch");

  // ************************************************************
  // bit operation checks
  // ************************************************************
  // port clear keeps flags
  a_port_clr_flags: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    bit_clear_op_port && !i_flag_wr |=> $stable(flag_q))
    else $error("port bit clear touched flags");
  a_mem_bit_clear: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    bit_clear_op_mem |=> o_mem_we && (o_mem_wdata == ($past(i_mem_rdata) & ~$past(mask_w))))
    else $error("memory bit clear wrong");
  // memory bit ops keep flags and port
  a_mem_bit_flags: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (bit_clear_op_mem || bit_force_high_op_mem) && !i_flag_wr |=> $stable(flag_q)
      && $stable(o_port_data))
    else $error("memory bit op touched flags or port");
  // write strobe only after a memory op
  a_mem_we_cause: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    o_mem_we |-> $past(mem_op_w))
    else $error("memory write without a memory op");
  // bit select is one-hot at index n
  a_mask_onehot: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    $onehot(mask_w) && mask_w[i_bit_idx])
    else $error("bit select mask wrong");
  // software write reaches borrow at bit one
  a_flag_write: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_flag_wr && !go_w |=> flag_q[`ICBOU_FLG_BORR] == $past(i_flag_wdata[1]))
    else $error("flag write missed the borrow bit");

  // ************************************************************
  // exchange checks
  // ************************************************************
  // exchange hands old latch bit to borrow
  a_xch_borrow: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    op_xch && sel_out_w |=> flag_q[`ICBOU_FLG_BORR] == $past(|(port_q & mask_w)))
    else $error("exchange did not load old port bit");
  a_xch_flags: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    op_xch && !i_flag_wr |=> no_borr_f_w == $past(no_borr_f_w))
    else $error("exchange touched flags other than borrow");
  // exchange on a memory operand is refused
  a_xch_refused: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    xch_mem_w && !i_flag_wr |=> $stable(flag_q) && $stable(o_port_data) && !o_mem_we)
    else $error("refused exchange changed state");
  // direction bit one drives old borrow out
  a_dir_output: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    op_xch && i_port_dir[i_bit_idx] |=> o_port_data[$past(i_bit_idx)] == $past(old_borr_w))
    else $error("output direction did not take borrow");
endmodule

// ---- shared/icbou_defines.svh ----
// named constants for the invert, compare and bit-operation unit
// assumes inclusion by bare name from design files
`ifndef ICBOU_DEFINES_SVH
`define ICBOU_DEFINES_SVH
// data width of working register, memory byte and port
`define ICBOU_DW        8
// flag register positions
`define ICBOU_FLG_NULL  0
`define ICBOU_FLG_BORR  1
`define ICBOU_FLG_HALF  2
`define ICBOU_FLG_WRAP  3
// flag register width
`define ICBOU_FW        4
// reset values
`define ICBOU_RST_BYTE  8'h00
`define ICBOU_RST_FLAG  4'h0
`endif

// ---- shared/icbou_pkg.sv ----
// types of the invert, compare and bit-operation unit
// assumes no other package
package icbou_pkg;
  // operation select, one-hot codes
  typedef enum logic [9:0] {
    ICBOU_OP_NONE      = 10'h001,
    ICBOU_OP_NOT_WREG  = 10'h002,
    ICBOU_OP_NOT_MEM   = 10'h004,
    ICBOU_OP_NEG_WREG  = 10'h008,
    ICBOU_OP_NEG_MEM   = 10'h010,
    ICBOU_OP_CMP_WM    = 10'h020,
    ICBOU_OP_CMP_MW    = 10'h040,
    ICBOU_OP_PORT_CLR  = 10'h080,
    ICBOU_OP_PORT_SET  = 10'h100,
    ICBOU_OP_PORT_XCH  = 10'h200
  } icbou_op_t;
  // bit-clear and bit-force-high on memory reuse the port codes with i_mem_sel
endpackage

// ---- shared/icbou_sub_if.sv ----
// carrier between the top and the subtract/flag helper
// assumes both ends run on the same clock
interface icbou_sub_if;
  logic [7:0] minuend;     // left operand
  logic [7:0] subtrahend;  // right operand
  logic       null_f;      // difference is zero
  logic       borr_f;      // minuend below subtrahend
  logic       half_f;      // borrow out of low nibble
  logic       wrap_f;      // signed overflow
  modport req (output minuend, output subtrahend,
               input null_f, input borr_f, input half_f, input wrap_f);
  modport rsp (input minuend, input subtrahend,
               output null_f, output borr_f, output half_f, output wrap_f);
endinterface

// ---- hw/icbou_sub.sv ----
// subtract-test flag generator, purely combinational
// assumes operands stable for the evaluating cycle
module icbou_sub (
  icbou_sub_if.rsp s
);
  // nine-bit difference for borrow out
  wire [8:0] diff_w = {1'b0, s.minuend} - {1'b0, s.subtrahend};
  // five-bit low-nibble difference for half borrow
  wire [4:0] lo_w   = {1'b0, s.minuend[3:0]} - {1'b0, s.subtrahend[3:0]};
  assign s.null_f = (diff_w[7:0] == 8'h00);
  assign s.borr_f = diff_w[8];
  assign s.half_f = lo_w[4];
  // signs differ and result sign differs from minuend
  assign s.wrap_f = (s.minuend[7] ^ s.subtrahend[7]) & (s.minuend[7] ^ diff_w[7]);
endmodule

// ---- hw/icbou_bitsel.sv ----
// one-hot bit mask decoder for single-bit operations
// assumes a 3-bit index
module icbou_bitsel #(
  parameter int W = 8
) (
  input  wire logic [2:0]   i_idx,
  output wire logic [W-1:0] o_mask
);
  // a 3-bit index reaches at most eight positions
  if (W < 1 || W > 8) begin : g_bad_w
    $error("icbou_bitsel width must lie between 1 and 8");
  end
  // one generate entry per bit position
  for (genvar g = 0; g < W; g++) begin : g_bit
    assign o_mask[g] = (i_idx == 3'(g));
  end
endmodule

// ---- testbench/icbou_tb.sv ----
// self-checking bench for the invert, compare and bit-operation unit
// assumes icbou_pkg and the design files are compiled before it
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // notes and signals
  // ****************************************
  // expected outputs of one taken cycle; masks hide unknowable bits
  typedef struct packed {
    logic [7:0] w;
    logic [7:0] p;
    logic [7:0] pm;
    logic [3:0] f;
    logic [3:0] fm;
    logic [7:0] m;
    logic       e;
  } icbou_note_t;
  logic                 i_clk;
  logic                 i_sys_rst       = 1'b1;
  logic                 i_valid         = 1'b0;
  icbou_pkg::icbou_op_t i_op            = icbou_pkg::ICBOU_OP_NONE;
  logic                 i_mem_sel       = 1'b0;
  logic [2:0]           i_bit_idx       = 3'h0;
  logic [7:0]           i_mem_rdata     = 8'h00;
  logic [7:0]           i_port_dir      = 8'h00;
  logic [7:0]           i_port_one_pins = 8'h00;
  logic                 i_flag_wr       = 1'b0;
  logic [3:0]           i_flag_wdata    = 4'h0;
  logic                 i_wreg_wr       = 1'b0;
  logic [7:0]           i_wreg_wdata    = 8'h00;
  logic [7:0]           o_working_reg;
  logic [7:0]           o_port_data;
  logic [3:0]           o_flags;
  logic [7:0]           o_mem_wdata;
  logic                 o_mem_we;
  // reference state: register, latch, flags, unknown-bit marks
  logic [7:0]           m_w, m_p, p_dc;
  logic [3:0]           m_f;
  logic                 f_dc;
  icbou_note_t          q[$];
  int                   errors  = 0;
  int                   checked = 0;
  int                   seed    = 98;
  int                   cyc     = 0;
  icbou_top dut (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_valid(i_valid), .i_op(i_op),
    .i_mem_sel(i_mem_sel), .i_bit_idx(i_bit_idx), .i_mem_rdata(i_mem_rdata),
    .i_port_dir(i_port_dir), .i_port_one_pins(i_port_one_pins),
    .i_flag_wr(i_flag_wr), .i_flag_wdata(i_flag_wdata), .i_wreg_wr(i_wreg_wr),
    .i_wreg_wdata(i_wreg_wdata), .o_working_reg(o_working_reg),
    .o_port_data(o_port_data), .o_flags(o_flags), .o_mem_wdata(o_mem_wdata),
    .o_mem_we(o_mem_we)
  );
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  // ****************************************
  // helpers
  // ****************************************
  // flags of a minus b: {wrap, half, borrow, null}
  function automatic logic [3:0] subf(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] d;
    d = a - b;
    return {(a[7] ^ b[7]) & (a[7] ^ d[7]), a[3:0] < b[3:0], a < b, d == 8'h00};
  endfunction
  // one-hot op code by index, 0 is none
  function automatic icbou_pkg::icbou_op_t opk(input int k);
    return icbou_pkg::icbou_op_t'(10'h001 << k);
  endfunction
  task automatic cmp(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // drive one cycle, note its expected outcome, return after the taking edge
  task automatic run(input logic v, input icbou_pkg::icbou_op_t o, input logic s,
                     input logic [2:0] n, input logic [7:0] mem, input logic fw,
                     input logic [3:0] fd, input logic ww, input logic [7:0] wd);
    icbou_note_t t;
    logic        b, bd;
    i_valid = v;
    i_op = o;
    i_mem_sel = s;
    i_bit_idx = n;
    i_mem_rdata = mem;
    i_flag_wr = fw;
    i_flag_wdata = fd;
    i_wreg_wr = ww;
    i_wreg_wdata = wd;
    t.m = 8'h00;
    t.e = 1'b0;
    if (fw) {f_dc, m_f} = {1'b0, fd};
    if (ww) m_w = wd;
    if (v) begin
      case (o)
        icbou_pkg::ICBOU_OP_NOT_WREG: m_w = ~m_w;
        icbou_pkg::ICBOU_OP_NEG_WREG: m_w = -m_w;
        icbou_pkg::ICBOU_OP_NOT_MEM: {t.e, t.m} = {1'b1, ~mem};
        icbou_pkg::ICBOU_OP_NEG_MEM: {t.e, t.m} = {1'b1, -mem};
        icbou_pkg::ICBOU_OP_CMP_WM: {f_dc, m_f} = {1'b0, subf(m_w, mem)};
        icbou_pkg::ICBOU_OP_CMP_MW: {f_dc, m_f} = {1'b0, subf(mem, m_w)};
        icbou_pkg::ICBOU_OP_PORT_CLR: begin
          if (s) {t.e, t.m} = {1'b1, mem & ~(8'h01 << n)};
          else {p_dc[n], m_p[n]} = 2'b00;
        end
        icbou_pkg::ICBOU_OP_PORT_SET: begin
          if (s) {t.e, t.m} = {1'b1, mem | (8'h01 << n)};
          else {p_dc[n], m_p[n]} = 2'b01;
        end
        icbou_pkg::ICBOU_OP_PORT_XCH: begin
          // output swaps latch and borrow; input loads pin, latch kept
          if (!s && i_port_dir[n]) begin
            b = m_p[n];
            bd = p_dc[n];
            {p_dc[n], m_p[n]} = {f_dc, m_f[1]};
            {f_dc, m_f[1]} = {bd, b};
          end else if (!s) begin
            {f_dc, m_f[1]} = {1'b0, i_port_one_pins[n]};
          end
        end
        default: ;
      endcase
      if (o == opk(1) || o == opk(3)) m_f[0] = (m_w == 8'h00);
      if (o == opk(2) || o == opk(4)) m_f[0] = (t.m == 8'h00);
    end
    {t.w, t.p, t.pm, t.f, t.fm} = {m_w, m_p, ~p_dc, m_f, ~{2'b00, f_dc, 1'b0}};
    @(posedge i_clk);
    // queued at the taking edge so the watcher pairs it with this edge
    q.push_back(t);
    #1;
  endtask
  task automatic ld(input logic fw, input logic [3:0] fd, input logic ww,
                    input logic [7:0] wd);
    run(1'b0, opk(0), 1'b0, 3'h0, 8'h00, fw, fd, ww, wd);
  endtask
  task automatic op(input int k, input logic s, input logic [2:0] n, input logic [7:0] mem);
    run(1'b1, opk(k), s, n, mem, 1'b0, 4'h0, 1'b0, 8'h00);
  endtask
  task automatic do_reset();
    i_valid = 1'b0;
    @(posedge i_clk);
    #1;
    i_sys_rst = 1'b1;
    repeat (12) @(posedge i_clk);
    #1;
    i_sys_rst = 1'b0;
    {m_w, m_p, p_dc, m_f, f_dc} = '0;
    cmp("working_reg", 8'h00, o_working_reg);
    cmp("port_data", 8'h00, o_port_data);
    cmp("flags", 8'h00, {4'h0, o_flags});
    cmp("mem_we", 8'h00, {7'h00, o_mem_we});
  endtask
  task automatic tally_and_finish();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ****************************************
  // watcher: oldest note against settled outputs
  // ****************************************
  always @(posedge i_clk) begin
    icbou_note_t t;
    #2;
    if (q.size() > 0) begin
      t = q.pop_front();
      cmp("working_reg", t.w, o_working_reg);
      cmp("port_data", t.p & t.pm, o_port_data & t.pm);
      cmp("flags", {4'h0, t.f & t.fm}, {4'h0, o_flags & t.fm});
      cmp("mem_we", {7'h00, t.e}, {7'h00, o_mem_we});
      if (t.e) cmp("mem_wdata", t.m, o_mem_wdata);
    end
  end
  // hang guard
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 2000) begin
      errors++;
      tally_and_finish();
    end
  end
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    int          k;
    logic [31:0] r;
    do_reset();
    ld(1'b1, 4'he, 1'b1, 8'h38);
    op(1, 1'b0, 3'h0, 8'h00);
    ld(1'b0, 4'h0, 1'b1, 8'h38);
    op(3, 1'b0, 3'h0, 8'h00);
    ld(1'b0, 4'h0, 1'b1, 8'h00);
    op(3, 1'b0, 3'h0, 8'h00);
    op(2, 1'b0, 3'h0, 8'h38);
    op(2, 1'b0, 3'h0, 8'hff);
    op(4, 1'b0, 3'h0, 8'h38);
    $display("test unary done");
    ld(1'b0, 4'h0, 1'b1, 8'h38);
    op(5, 1'b0, 3'h0, 8'h38);
    op(5, 1'b0, 3'h0, 8'h42);
    op(6, 1'b0, 3'h0, 8'h42);
    op(6, 1'b0, 3'h0, 8'hb8);
    run(1'b1, opk(5), 1'b0, 3'h0, 8'h80, 1'b1, 4'h0, 1'b0, 8'h00);
    $display("test compare done");
    for (int n = 0; n < 8; n++) op(8, 1'b0, n[2:0], 8'h00);
    for (int n = 0; n < 8; n++) op(7, 1'b0, n[2:0], 8'h00);
    op(7, 1'b1, 3'h3, 8'hff);
    op(8, 1'b1, 3'h7, 8'h00);
    i_port_dir = 8'hff;
    ld(1'b1, 4'h2, 1'b0, 8'h00);
    op(9, 1'b0, 3'h4, 8'h00);
    op(9, 1'b0, 3'h4, 8'h00);
    i_port_dir = 8'h00;
    i_port_one_pins = 8'h40;
    op(9, 1'b0, 3'h6, 8'h00);
    i_port_one_pins = 8'h00;
    op(9, 1'b0, 3'h6, 8'h00);
    op(9, 1'b1, 3'h6, 8'h00);
    run(1'b0, opk(1), 1'b0, 3'h0, 8'h00, 1'b0, 4'h0, 1'b0, 8'h00);
    $display("test bit ops done");
    for (int i = 0; i < 300; i++) begin
      k = $unsigned($random(seed)) % 10;
      r = $random(seed);
      i_port_dir = $random(seed);
      i_port_one_pins = $random(seed);
      run(1'b1, opk(k), k > 6 && r[0], r[3:1], r[15:8], k == 0 && r[4], r[19:16],
          k == 0 && r[5], r[27:20]);
    end
    $display("test random done");
    do_reset();
    op(1, 1'b0, 3'h0, 8'h00);
    i_valid = 1'b0;
    repeat (2) @(posedge i_clk);
    $display("test second reset done");
    #3;
    tally_and_finish();
  end
endmodule
